// File: logic/mrs_core.sv
// Modem core: rate generation, bit sync, sync word insert/search, offset estimate.
// Assumes rx_pin is asynchronous; all other inputs come from mclk logic.
`timescale 1ns/10ps
module mrs_core #(
	parameter int XOSC_KHZ = mrs_pkg::XOSC_KHZ_DEF
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire mrs_pkg::mrs_cfg_t cfg,
	input wire logic rx_enable,
	input wire logic rx_restart,
	input wire logic rx_pin,
	input wire logic signed [mrs_pkg::OFS_W-1:0] rx_freq,
	input wire logic rx_freq_valid,
	input wire logic carrier_sense,
	input wire logic [7:0] preamble_quality_indicator,
	input wire logic [mrs_pkg::OFS_W-1:0] synth_offset_field,
	input wire logic tx_start,
	input wire logic tx_stop,
	input wire logic [7:0] tx_data,
	output logic tx_active,
	output logic tx_bit,
	output logic tx_sym_tick,
	output logic tx_data_take,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic packet_start,
	output mrs_pkg::mrs_stat_t status,
	output logic [mrs_pkg::OFS_W-1:0] synth_freq_offset
);
	typedef enum logic [1:0] {MRS_TX_IDLE, MRS_TX_SYNC, MRS_TX_DATA} mrs_tx_t;

	initial
	begin
		if (XOSC_KHZ < 1000 || XOSC_KHZ / (mrs_pkg::BW_DIV * mrs_pkg::BW_BASE) >= 4096)
			$error("mrs_core: XOSC_KHZ out of range");
	end

	logic sym_tick;
	logic os_tick;
	logic sync32;
	logic [31:0] pattern;
	assign sync32 = cfg.sync_mode[1:0] == mrs_pkg::THR_30_32;
	assign pattern = {cfg.sync_word_high, cfg.sync_word_low,
		cfg.sync_word_high, cfg.sync_word_low};

	// Symbol-rate ticks for transmit, 16x oversampled ticks for receive
	mrs_rate_gen #(.ACC_W(mrs_pkg::RATE_ACC_W)) u_tx_rate (
		.mclk(mclk), .rst_b(rst_b), .enable(tx_active),
		.mantissa(cfg.rate_mantissa), .exponent(cfg.rate_exponent),
		.tick(sym_tick));
	mrs_rate_gen #(.ACC_W(mrs_pkg::RATE_ACC_W - mrs_pkg::OVS_LOG2)) u_rx_rate (
		.mclk(mclk), .rst_b(rst_b), .enable(rx_enable),
		.mantissa(cfg.rate_mantissa), .exponent(cfg.rate_exponent),
		.tick(os_tick));

	// Transmit: sync word MSB first, then bytes on demand
	mrs_tx_t tx_state_reg;
	logic [31:0] tx_shift_reg;
	logic [5:0] tx_cnt_reg;
	logic [2:0] tx_bitn_reg;
	logic [5:0] sync_len;
	assign sync_len = sync32 ? mrs_pkg::SYNC_LEN32 : mrs_pkg::SYNC_LEN16;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			tx_state_reg <= MRS_TX_IDLE;
			tx_shift_reg <= '0;
			tx_cnt_reg <= '0;
			tx_bitn_reg <= '0;
			tx_bit <= 1'b0;
			tx_data_take <= 1'b0;
		end
		else
		begin
			tx_data_take <= 1'b0;
			unique case (tx_state_reg)
				MRS_TX_IDLE:
					if (tx_start)
					begin
						tx_state_reg <= MRS_TX_SYNC;
						tx_shift_reg <= pattern;
						tx_cnt_reg <= sync_len;
					end
				MRS_TX_SYNC:
					if (tx_stop)
						tx_state_reg <= MRS_TX_IDLE;
					else if (sym_tick)
					begin
						tx_bit <= tx_shift_reg[31];
						tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
						tx_cnt_reg <= tx_cnt_reg - 6'h01;
						if (tx_cnt_reg == 6'h01)
						begin
							tx_state_reg <= MRS_TX_DATA;
							tx_shift_reg <= {tx_data, 24'h000000};
							tx_bitn_reg <= '0;
							tx_data_take <= 1'b1;
						end
					end
				MRS_TX_DATA:
					if (tx_stop)
						tx_state_reg <= MRS_TX_IDLE;
					else if (sym_tick)
					begin
						tx_bit <= tx_shift_reg[31];
						tx_bitn_reg <= tx_bitn_reg + 3'h1;
						tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
						if (tx_bitn_reg == mrs_pkg::BYTE_LAST)
						begin
							tx_shift_reg <= {tx_data, 24'h000000};
							tx_data_take <= 1'b1;
						end
					end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			tx_active <= 1'b0;
			tx_sym_tick <= 1'b0;
		end
		else
		begin
			tx_active <= (tx_state_reg != MRS_TX_IDLE || tx_start) && !tx_stop;
			tx_sym_tick <= sym_tick;
		end
	end

	// Receive pin: three flops, a change counts once stages two and three agree
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic rx_s3_reg;
	logic rx_level_reg;
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			rx_s1_reg <= 1'b0;
			rx_s2_reg <= 1'b0;
			rx_s3_reg <= 1'b0;
			rx_level_reg <= 1'b0;
		end
		else
		begin
			rx_s1_reg <= rx_pin;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_level_reg <= rx_s3_reg;
		end
	end

	// Bit sync: edges should land at phase 0, sample at mid-symbol
	logic [3:0] phase_reg;
	logic prev_level_reg;
	logic bit_strobe_reg;
	logic rx_bit_reg;
	logic edge_seen;
	assign edge_seen = os_tick && rx_level_reg != prev_level_reg;
	always_ff @(posedge mclk)
	begin
		if (!rst_b || !rx_enable)
		begin
			phase_reg <= '0;
			prev_level_reg <= 1'b0;
			bit_strobe_reg <= 1'b0;
			rx_bit_reg <= 1'b0;
		end
		else
		begin
			bit_strobe_reg <= os_tick && phase_reg == mrs_pkg::PH_SAMPLE;
			if (os_tick)
			begin
				prev_level_reg <= rx_level_reg;
				if (phase_reg == mrs_pkg::PH_SAMPLE)
					rx_bit_reg <= rx_level_reg;
				if (edge_seen && phase_reg != 4'h0 && phase_reg < mrs_pkg::PH_SAMPLE)
					phase_reg <= phase_reg;
				else if (edge_seen && phase_reg > mrs_pkg::PH_SAMPLE)
					phase_reg <= phase_reg + 4'h2;
				else
					phase_reg <= phase_reg + 4'h1;
			end
		end
	end

	// Sync search over a sliding bit history
	logic [31:0] hist_reg;
	logic [5:0] count16;
	logic [5:0] count32;
	logic corr_valid;
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			hist_reg <= '0;
		else if (bit_strobe_reg)
			hist_reg <= {hist_reg[30:0], rx_bit_reg};
	end

	mrs_sync_corr u_corr (
		.mclk(mclk), .rst_b(rst_b), .strobe(bit_strobe_reg),
		.history({hist_reg[30:0], rx_bit_reg}), .pattern(pattern),
		.count16(count16), .count32(count32), .valid(corr_valid));

	logic hit;
	logic qual;
	logic cs_seen_reg;
	always_comb
	begin
		unique case (cfg.sync_mode[1:0])
			mrs_pkg::THR_NONE: hit = carrier_sense;
			mrs_pkg::THR_15_16: hit = count16 >= mrs_pkg::CNT_15;
			mrs_pkg::THR_16_16: hit = count16 == mrs_pkg::CNT_16;
			mrs_pkg::THR_30_32: hit = count32 >= mrs_pkg::CNT_30;
		endcase
	end
	assign qual = (!cfg.sync_mode[2] || carrier_sense) &&
		(!cfg.pqi_qualify_en || preamble_quality_indicator > cfg.pqi_threshold);

	logic [2:0] rx_bitn_reg;
	logic [7:0] rx_acc_reg;
	always_ff @(posedge mclk)
	begin
		if (!rst_b || !rx_enable || rx_restart)
		begin
			status.sync_found <= 1'b0;
			packet_start <= 1'b0;
			rx_bitn_reg <= '0;
			rx_acc_reg <= '0;
			rx_byte <= '0;
			rx_byte_valid <= 1'b0;
		end
		else
		begin
			packet_start <= 1'b0;
			rx_byte_valid <= 1'b0;
			if (!status.sync_found && corr_valid && hit && qual)
			begin
				status.sync_found <= 1'b1;
				packet_start <= 1'b1;
				rx_bitn_reg <= '0;
			end
			else if (status.sync_found && bit_strobe_reg)
			begin
				rx_acc_reg <= {rx_acc_reg[6:0], rx_bit_reg};
				rx_bitn_reg <= rx_bitn_reg + 3'h1;
				if (rx_bitn_reg == mrs_pkg::BYTE_LAST)
				begin
					rx_byte <= {rx_acc_reg[6:0], rx_bit_reg};
					rx_byte_valid <= 1'b1;
				end
			end
		end
	end

	// Channel bandwidth readout and offset tracking limit
	logic [mrs_pkg::BW_W-1:0] bw_base;
	always_comb
	begin
		bw_base = mrs_pkg::BW_W'(XOSC_KHZ /
			(mrs_pkg::BW_DIV * (mrs_pkg::BW_BASE + int'(cfg.bw_mantissa))));
	end

	logic signed [mrs_pkg::OFS_W:0] lim;
	logic signed [mrs_pkg::OFS_W:0] est_ext;
	logic signed [mrs_pkg::OFS_W:0] err;
	logic signed [mrs_pkg::OFS_W:0] step;
	logic signed [mrs_pkg::OFS_W:0] nxt;
	logic [1:0] gain;
	logic comp_en;
	assign comp_en = cfg.mod_format != mrs_pkg::MOD_ASK && cfg.offset_range_limit != 2'h0;
	assign lim = (mrs_pkg::OFS_W+1)'(status.channel_bw_khz >> (3'h4 - 3'(cfg.offset_range_limit)));
	assign gain = status.sync_found ? cfg.offset_gain_after_sync
		: cfg.offset_gain_before_sync;
	assign est_ext = (mrs_pkg::OFS_W+1)'(signed'(status.offset_estimate_status));
	assign err = (mrs_pkg::OFS_W+1)'(rx_freq) - est_ext;
	assign step = err >>> (3'h1 + 3'(gain));
	assign nxt = est_ext + step;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			cs_seen_reg <= 1'b0;
		else if (carrier_sense)
			cs_seen_reg <= 1'b1;
		else if (rx_restart)
			cs_seen_reg <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			status.channel_bw_khz <= '0;
			status.offset_estimate_status <= '0;
			synth_freq_offset <= '0;
		end
		else
		begin
			status.channel_bw_khz <= bw_base >> cfg.bw_exponent;
			synth_freq_offset <= synth_offset_field;
			if (!comp_en)
				status.offset_estimate_status <= '0;
			else if (rx_freq_valid && !(cfg.offset_cs_gating && !cs_seen_reg))
			begin
				if (nxt > lim)
					status.offset_estimate_status <= lim[mrs_pkg::OFS_W-1:0];
				else if (nxt < -lim)
					status.offset_estimate_status <= mrs_pkg::OFS_W'(-lim);
				else
					status.offset_estimate_status <= nxt[mrs_pkg::OFS_W-1:0];
			end
		end
	end

	// Checks
	logic [2:0] since_sync_reg;
	always_ff @(posedge mclk)
	begin
		if (!rst_b || packet_start)
			since_sync_reg <= '0;
		else if (bit_strobe_reg && status.sync_found)
			since_sync_reg <= since_sync_reg + 3'h1;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	tx_msb_first_a: assert property (tx_state_reg == MRS_TX_SYNC && sym_tick && !tx_stop &&
		tx_cnt_reg == sync_len |=> tx_bit == cfg.sync_word_high[7])
		else $error("sync word not sent MSB first");
	sync_threshold_a: assert property ($rose(status.sync_found) && $past(rx_enable) &&
		$past(cfg.sync_mode[1:0]) == mrs_pkg::THR_16_16 |-> $past(count16) == 6'h10)
		else $error("sync accepted below threshold");
	sync_word_a: assert property ($rose(status.sync_found) && $past(cfg.sync_mode[1:0]) !=
		mrs_pkg::THR_NONE |-> $past(count16) >= mrs_pkg::CNT_15 ||
		$past(count32) >= mrs_pkg::CNT_30)
		else $error("sync found without correlation");
	sync_cs_a: assert property ($rose(status.sync_found) && $past(cfg.sync_mode[2])
		|-> $past(carrier_sense))
		else $error("sync without carrier sense");
	sync_pqi_a: assert property ($rose(status.sync_found) && $past(cfg.pqi_qualify_en)
		|-> $past(preamble_quality_indicator) > $past(cfg.pqi_threshold))
		else $error("sync with low preamble quality");
	offset_freeze_a: assert property (cfg.offset_cs_gating && !cs_seen_reg && comp_en
		&& !rx_restart |=> $stable(status.offset_estimate_status))
		else $error("offset moved before carrier sense");
	offset_ask_a: assert property (cfg.mod_format == mrs_pkg::MOD_ASK
		|=> status.offset_estimate_status == '0)
		else $error("offset tracked for ASK");
	offset_limit_a: assert property ($stable(cfg) && $stable(status.channel_bw_khz) ##1
		$stable(cfg) |-> est_ext <= lim && est_ext >= -lim)
		else $error("offset outside tracking range");
	byte_align_a: assert property (rx_byte_valid |-> since_sync_reg == 3'h0 &&
		$past(status.sync_found, 2))
		else $error("byte boundary off sync position");
	bit_resync_a: assert property (edge_seen && phase_reg > mrs_pkg::PH_SAMPLE
		&& rx_enable && !rx_restart |=> phase_reg == $past(phase_reg) + 4'h2)
		else $error("bit sync failed to advance");

	sync32_c: cover property (sync32 && $rose(status.sync_found));
	tx_take_c: cover property (tx_state_reg == MRS_TX_DATA && tx_data_take);
	rx_byte_c: cover property (rx_byte_valid);
	cs_release_c: cover property (cfg.offset_cs_gating && $rose(cs_seen_reg));
endmodule : mrs_core

// File: logic/mrs_pkg.sv
// Constants, types and field layouts shared by the modem rate/offset/sync core.
// Assumes every user sits on the single mclk domain.
// Contract
// - Symbol rate is fxosc times (256 plus mantissa) times 2^exponent over 2^28.
// - Rates from 0.6 to 500 kBaud; step doubles per exponent range.
// - Channel bandwidth is fxosc over 8 times (4 plus mantissa) times 2^exponent.
// - Offset compensation works for FSK-type modulations, never for ASK or OOK.
// - Offset tracking range is a selectable fraction of channel bandwidth.
// - With gating set, offset estimate stays frozen until carrier sense asserts.
// - Tracking gain switches from before-sync value to after-sync value.
// - Estimate is readable; host copy into synth offset shifts the synthesizer.
// - Bit sync recovers symbol clock at programmed rate, re-aligning continuously.
// - Continuous search for 16-bit sync word, optionally 32; inserted on transmit.
// - Sync word sent MSB first; byte boundaries follow the found sync word.
// - With sync detection enabled, only packets with the sync word are accepted.
// - Detection threshold selectable as 15/16, 16/16 or 30/32 matching bits.
// - Detection may need carrier sense and preamble quality above its threshold.
// - Sync pattern comes from two byte-wide configuration fields.
// - Sync mode 3 or 7 repeats the two bytes into a 32-bit pattern.
package mrs_pkg;
	localparam int RATE_BASE = 256;
	localparam int RATE_ACC_W = 28;
	localparam int OVS_LOG2 = 4;
	localparam int XOSC_KHZ_DEF = 26000;
	localparam int BW_DIV = 8;
	localparam int BW_BASE = 4;
	localparam int OFS_W = 12;
	localparam int BW_W = 12;
	localparam logic [3:0] PH_SAMPLE = 4'h8;
	localparam logic [2:0] MOD_ASK = 3'h3;
	localparam logic [1:0] THR_NONE = 2'h0;
	localparam logic [1:0] THR_15_16 = 2'h1;
	localparam logic [1:0] THR_16_16 = 2'h2;
	localparam logic [1:0] THR_30_32 = 2'h3;
	localparam logic [5:0] CNT_15 = 6'h0F;
	localparam logic [5:0] CNT_16 = 6'h10;
	localparam logic [5:0] CNT_30 = 6'h1E;
	localparam logic [5:0] SYNC_LEN16 = 6'h10;
	localparam logic [5:0] SYNC_LEN32 = 6'h20;
	localparam logic [2:0] BYTE_LAST = 3'h7;

	typedef struct packed {
		logic [7:0] rate_mantissa;
		logic [3:0] rate_exponent;
		logic [1:0] bw_mantissa;
		logic [1:0] bw_exponent;
		logic [2:0] mod_format;
		logic [2:0] sync_mode;
		logic [1:0] offset_range_limit;
		logic offset_cs_gating;
		logic [1:0] offset_gain_before_sync;
		logic [1:0] offset_gain_after_sync;
		logic [7:0] sync_word_high;
		logic [7:0] sync_word_low;
		logic pqi_qualify_en;
		logic [7:0] pqi_threshold;
	} mrs_cfg_t;

	typedef struct packed {
		logic [OFS_W-1:0] offset_estimate_status;
		logic [BW_W-1:0] channel_bw_khz;
		logic sync_found;
	} mrs_stat_t;
endpackage : mrs_pkg

// File: logic/mrs_rate_gen.sv
// Phase accumulator that turns mantissa and exponent into a tick rate.
// Assumes mantissa and exponent are quasi-static configuration.
`timescale 1ns/10ps
module mrs_rate_gen #(
	parameter int ACC_W = mrs_pkg::RATE_ACC_W
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic [7:0] mantissa,
	input wire logic [3:0] exponent,
	output logic tick
);
	localparam int SUM_W = ACC_W + 2;
	logic [ACC_W-1:0] acc_reg;
	logic [SUM_W-1:0] inc;
	logic [SUM_W-1:0] sum;

	initial
	begin
		if (ACC_W < 23)
			$error("mrs_rate_gen: ACC_W too small");
	end

	// Increment (256 + mantissa) << exponent; carry out is the tick
	assign inc = SUM_W'(9'(mrs_pkg::RATE_BASE) + {1'b0, mantissa}) << exponent;
	assign sum = {2'h0, acc_reg} + inc;

	always_ff @(posedge mclk)
	begin
		if (!rst_b || !enable)
		begin
			acc_reg <= '0;
			tick <= 1'b0;
		end
		else
		begin
			acc_reg <= sum[ACC_W-1:0];
			tick <= |sum[SUM_W-1:ACC_W];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	tick_on_wrap_a: assert property (enable && $past(enable) && tick &&
		$past(inc[SUM_W-1:ACC_W]) == '0 |-> acc_reg < $past(acc_reg))
		else $error("tick without accumulator wrap");
	no_tick_idle_a: assert property (!enable |=> !tick)
		else $error("tick while disabled");
endmodule : mrs_rate_gen

// File: logic/mrs_sync_corr.sv
// Sync word correlator: counts matching bits over the last 16 and 32 bits.
// Assumes the bit history and pattern come from the mclk domain.
`timescale 1ns/10ps
module mrs_sync_corr (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic strobe,
	input wire logic [31:0] history,
	input wire logic [31:0] pattern,
	output logic [5:0] count16,
	output logic [5:0] count32,
	output logic valid
);
	logic [31:0] agree;
	logic [5:0] sum16;
	logic [5:0] sum32;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++)
		begin : g_bit
			assign agree[gi] = ~(history[gi] ^ pattern[gi]);
		end
	endgenerate

	always_comb
	begin
		sum16 = '0;
		sum32 = '0;
		for (int i = 0; i < 32; i++)
		begin
			if (i < 16)
				sum16 = sum16 + 6'(agree[i]);
			sum32 = sum32 + 6'(agree[i]);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			count16 <= '0;
			count32 <= '0;
			valid <= 1'b0;
		end
		else
		begin
			valid <= strobe;
			if (strobe)
			begin
				count16 <= sum16;
				count32 <= sum32;
			end
		end
	end
endmodule : mrs_sync_corr

// File: tb/mrs_remote_tx.sv
// Remote transmitter model: drives the demodulated bit line of the core.
// Assumes the bench sets sym_cycles above 1 before the first clock edge.
`timescale 1ns/10ps
module mrs_remote_tx (
	input wire logic mclk,
	input wire logic go,
	input wire logic [31:0] pattern,
	input wire logic [5:0] nbits,
	input wire logic [7:0] data,
	input wire logic [7:0] sym_cycles,
	output logic line,
	output logic busy
);
	int i;

	task automatic send(input logic b);
		@(posedge mclk);
		line <= b;
		repeat (sym_cycles - 8'd1) @(posedge mclk);
	endtask : send

	// Alternating preamble while idle, so the line never rests
	initial
	begin
		line = 1'b0;
		busy = 1'b0;
		forever
		begin
			if (go !== 1'b1)
				send(~line);
			else
			begin
				busy <= 1'b1;
				for (i = 0; i < 16; i++)
					send(~line);
				for (i = 31; i >= 32 - int'(nbits); i--)
					send(pattern[i]);
				for (i = 7; i >= 0; i--)
					send(data[i]);
				for (i = 0; i < 8; i++)
					send(~line);
				busy <= 1'b0;
			end
		end
	end
endmodule : mrs_remote_tx

// File: tb/tb_modem_rate_offset_sync_core.sv
// Self-checking bench for the modem core: offset, bandwidth, transmit, sync search.
// Assumes a 10 MHz mclk and the remote transmitter model on rx_pin.
`timescale 1ns/10ps
module tb_modem_rate_offset_sync_core;
	logic mclk, rst_b, rx_enable, rx_restart, rx_pin, rx_freq_valid, carrier_sense;
	logic tx_start, tx_stop, tx_active, tx_bit, tx_sym_tick, tx_data_take;
	logic rx_byte_valid, packet_start, tx_go, tx_busy;
	logic [7:0] preamble_quality_indicator, tx_data, rx_byte, tx_per;
	logic [11:0] rx_freq, synth_offset_field, synth_freq_offset;
	logic [31:0] tx_pat;
	logic [5:0] tx_nb;
	mrs_pkg::mrs_cfg_t cfg;
	mrs_pkg::mrs_stat_t status;
	int fails, checked, cyc;

	mrs_core mrs_core_i (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .rx_enable(rx_enable),
		.rx_restart(rx_restart), .rx_pin(rx_pin), .rx_freq(rx_freq),
		.rx_freq_valid(rx_freq_valid), .carrier_sense(carrier_sense),
		.preamble_quality_indicator(preamble_quality_indicator),
		.synth_offset_field(synth_offset_field), .tx_start(tx_start), .tx_stop(tx_stop),
		.tx_data(tx_data), .tx_active(tx_active), .tx_bit(tx_bit), .tx_sym_tick(tx_sym_tick),
		.tx_data_take(tx_data_take), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
		.packet_start(packet_start), .status(status), .synth_freq_offset(synth_freq_offset));

	mrs_remote_tx mrs_remote_tx_i (.mclk(mclk), .go(tx_go), .pattern(tx_pat), .nbits(tx_nb),
		.data(8'h5A), .sym_cycles(tx_per), .line(rx_pin), .busy(tx_busy));

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fails++;
			end_sim();
		end
	end

	// Pulse a frequency sample n times, then read the estimate
	task automatic ofs(input logic [11:0] f, input int n, input logic [11:0] exp);
		repeat (n)
		begin
			@(posedge mclk);
			rx_freq <= f;
			rx_freq_valid <= 1'b1;
			@(posedge mclk);
			rx_freq_valid <= 1'b0;
		end
		repeat (2) @(posedge mclk);
		chk(status.offset_estimate_status, exp);
	endtask : ofs

	task automatic tx_test;
		int tk [40];
		logic [39:0] bits;
		int k;
		int n;
		@(posedge mclk);
		cfg.rate_mantissa <= 8'h80;
		cfg.sync_mode <= 3'h3;
		tx_data <= 8'hA5;
		tx_start <= 1'b1;
		@(posedge mclk);
		tx_start <= 1'b0;
		k = 0;
		n = 0;
		while (k < 40 && n < 6000)
		begin
			@(posedge mclk);
			n++;
			if (tx_data_take === 1'b1)
				tx_data <= 8'h3C;
			if (tx_sym_tick === 1'b1)
			begin
				bits[39 - k] = tx_bit;
				tk[k] = n;
				k++;
			end
		end
		chk(bits[39:8], 32'hD391D391);
		chk(bits[7:0], 8'hA5);
		chk(32'(tk[3] - tk[0]), 32'd256);
		chk(32'(tk[33] - tk[30]), 32'd256);
		chk(tx_active, 1'b1);
		tx_stop <= 1'b1;
		@(posedge mclk);
		tx_stop <= 1'b0;
		@(posedge mclk);
		chk(tx_active, 1'b0);
		cfg.rate_mantissa <= 8'h00;
	endtask : tx_test

	task automatic rx_run(input logic [2:0] mode, input logic [31:0] pat, input logic [5:0] nb,
		input logic [7:0] per, input logic exp_ok);
		int n;
		logic seen;
		logic [7:0] got;
		seen = 1'b0;
		got = 8'h00;
		@(posedge mclk);
		cfg.sync_mode <= mode;
		rx_restart <= 1'b1;
		tx_pat <= pat;
		tx_nb <= nb;
		tx_per <= per;
		tx_go <= 1'b1;
		@(posedge mclk);
		rx_restart <= 1'b0;
		n = 0;
		while (tx_busy !== 1'b1 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		tx_go <= 1'b0;
		while (tx_busy === 1'b1 && n < 12000)
		begin
			@(posedge mclk);
			n++;
			if (packet_start === 1'b1)
				seen = 1'b1;
			if (seen && rx_byte_valid === 1'b1 && got == 8'h00)
				got = rx_byte;
		end
		chk(seen, exp_ok);
		if (exp_ok)
			chk(got, 8'h5A);
	endtask : rx_run

	// Sync search off: carrier sense alone, preamble quality just above threshold
	task automatic nosync_test;
		@(posedge mclk);
		cfg.sync_mode <= 3'h0;
		preamble_quality_indicator <= 8'h81;
		rx_restart <= 1'b1;
		@(posedge mclk);
		rx_restart <= 1'b0;
		repeat (300) @(posedge mclk);
		chk(status.sync_found, 1'b1);
	endtask : nosync_test

	initial
	begin
		cfg = '0;
		cfg.rate_exponent = 4'hD;
		cfg.sync_word_high = 8'hD3;
		cfg.sync_word_low = 8'h91;
		cfg.sync_mode = 3'h2;
		cfg.offset_range_limit = 2'h3;
		cfg.offset_gain_after_sync = 2'h1;
		{rst_b, rx_enable, rx_restart, rx_freq_valid, carrier_sense} = 5'h00;
		{tx_start, tx_stop, tx_go} = 3'h0;
		{rx_freq, synth_offset_field} = 24'h000000;
		preamble_quality_indicator = 8'hC0;
		tx_data = 8'h00;
		tx_per = 8'd128;
		tx_pat = 32'h00000000;
		tx_nb = 6'h10;
		fails = 0;
		checked = 0;
		cyc = 0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({tx_active, packet_start, status.sync_found}, 3'h0);
		rx_enable <= 1'b1;
		ofs(12'h064, 1, 12'h032);
		ofs(12'h064, 1, 12'h04B);
		cfg.mod_format <= mrs_pkg::MOD_ASK;
		ofs(12'h064, 1, 12'h000);
		cfg.mod_format <= 3'h0;
		ofs(12'h064, 1, 12'h032);
		cfg.offset_range_limit <= 2'h0;
		ofs(12'h064, 1, 12'h000);
		cfg.offset_range_limit <= 2'h1;
		ofs(12'h190, 12, 12'h065);
		ofs(12'hE70, 12, 12'hF9B);
		cfg.offset_range_limit <= 2'h3;
		cfg.offset_cs_gating <= 1'b1;
		ofs(12'h000, 12, 12'hF9B);
		ofs(12'h064, 1, 12'hF9B);
		carrier_sense <= 1'b1;
		ofs(12'h064, 1, 12'hFFF);
		cfg.offset_cs_gating <= 1'b0;
		ofs(12'h001, 1, 12'h000);
		synth_offset_field <= 12'hFCE;
		repeat (2) @(posedge mclk);
		chk(synth_freq_offset, 12'hFCE);
		cfg.bw_mantissa <= 2'h1;
		repeat (3) @(posedge mclk);
		chk(status.channel_bw_khz, 12'd650);
		cfg.bw_exponent <= 2'h1;
		repeat (3) @(posedge mclk);
		chk(status.channel_bw_khz, 12'd325);
		cfg.bw_mantissa <= 2'h0;
		cfg.bw_exponent <= 2'h0;
		tx_test();
		rx_run(3'h2, 32'hD3910000, 6'h10, 8'd129, 1'b1);
		chk(status.sync_found, 1'b1);
		ofs(12'h064, 1, 12'h019);
		rx_run(3'h1, 32'hD3900000, 6'h10, 8'd127, 1'b1);
		rx_run(3'h2, 32'hD3900000, 6'h10, 8'd128, 1'b0);
		rx_run(3'h3, 32'hD391D391, 6'h20, 8'd128, 1'b1);
		carrier_sense <= 1'b0;
		rx_run(3'h6, 32'hD3910000, 6'h10, 8'd128, 1'b0);
		carrier_sense <= 1'b1;
		cfg.pqi_qualify_en <= 1'b1;
		cfg.pqi_threshold <= 8'h80;
		preamble_quality_indicator <= 8'h80;
		rx_run(3'h2, 32'hD3910000, 6'h10, 8'd128, 1'b0);
		nosync_test();
		end_sim();
	end
endmodule : tb_modem_rate_offset_sync_core
